// ---- verilog/oas_pkg.sv ----
// Purpose: Shared constants and types for the operand address and stack pointer block.
// Assumes: One 50 MHz core clock; register bytes are eight bits wide.
// Notes: Offsets are register-file addresses as seen by the plain register port.
package oas_pkg;

  // Register-file addresses of the registers kept in this block.
  localparam logic [7:0] OAS_OFS_WP0 = 8'hD6;
  localparam logic [7:0] OAS_OFS_WP1 = 8'hD7;
  localparam logic [7:0] OAS_OFS_SPH = 8'hD8;
  localparam logic [7:0] OAS_OFS_SPL = 8'hD9;

  // Window pointers select the common working area after reset.
  localparam logic [7:0] OAS_WP0_RST = 8'hC0;
  localparam logic [7:0] OAS_WP1_RST = 8'hC8;

  // First address of the mapped control range that pointer forms cannot reach.
  localparam logic [7:0] OAS_SET1_BASE = 8'hC0;

  // Upper nibble of an 8-bit register field that means a working register.
  localparam logic [3:0] OAS_WORK_PREFIX = 4'hC;

  // Upper byte of every vector location in program memory.
  localparam logic [7:0] OAS_VEC_PAGE = 8'h00;

  // Miscellaneous values.
  localparam logic [7:0] OAS_BYTE_ZERO = 8'h00;
  localparam logic [15:0] OAS_WORD_ZERO = 16'h0000;
  localparam logic [15:0] OAS_ONE = 16'h0001;

  // Addressing mode of the operand being resolved.
  typedef enum logic [2:0] {
    OAS_M_REG = 3'b000,
    OAS_M_WORK = 3'b001,
    OAS_M_DEREF = 3'b010,
    OAS_M_INDEX = 3'b011,
    OAS_M_ABS = 3'b100,
    OAS_M_VEC = 3'b101
  } oas_mode_e;

  // Instruction class, as far as addressing cares.
  typedef enum logic [2:0] {
    OAS_C_OTHER = 3'b000,
    OAS_C_LOAD = 3'b001,
    OAS_C_PMLOAD = 3'b010,
    OAS_C_XLOAD = 3'b011,
    OAS_C_JUMP = 3'b100,
    OAS_C_CALL = 3'b101
  } oas_cls_e;

  // Stack action requested along with the operand.
  typedef enum logic [1:0] {
    OAS_K_NONE = 2'b00,
    OAS_K_PUSH = 2'b01,
    OAS_K_POP = 2'b10
  } oas_stk_e;

  // Space that a resolved address belongs to.
  typedef enum logic [1:0] {
    OAS_T_RF = 2'b00,
    OAS_T_PM = 2'b01,
    OAS_T_XM = 2'b10,
    OAS_T_PC = 2'b11
  } oas_target_e;

  // One decoded operand request.
  typedef struct packed {
    logic valid;
    oas_mode_e mode;
    oas_cls_e cls;
    oas_stk_e stk;
    logic wide;
    logic short_ofs;
    logic [3:0] wreg;
    logic [7:0] field8;
    logic [15:0] field16;
  } oas_req_s;

  // One resolved operand address.
  typedef struct packed {
    logic valid;
    logic fault;
    oas_target_e target;
    logic [15:0] addr;
  } oas_resp_s;

endpackage : oas_pkg

// ---- verilog/oas_window_sel.sv ----
// Purpose: Forms a register-file address from a 4-bit working register field.
// Assumes: Window pointers are stable while the field is being resolved.
// Notes: Pure combinational; instantiated once per field that needs it.
`timescale 1ns/1ps
module oas_window_sel (
  // Working register field.
  input wire logic [3:0] nibble,
  // Window pointers.
  input wire logic [7:0] window_pointer_zero,
  input wire logic [7:0] window_pointer_one,
  // Resulting register-file address.
  output logic [7:0] addr
);

  logic [7:0] chosen;

  // The top bit picks a pointer, whose upper five bits name an 8-byte slice.
  assign chosen = nibble[3] ? window_pointer_one : window_pointer_zero;
  assign addr = {chosen[7:3], nibble[2:0]};

endmodule : oas_window_sel

// ---- verilog/oas_index_add.sv ----
// Purpose: Adds an instruction offset to a 16-bit base held in a register pair.
// Assumes: The short offset is a two's-complement byte.
// Notes: The sum wraps at 16 bits, like any address counter of the core.
`timescale 1ns/1ps
module oas_index_add (
  // Base from the working register pair.
  input wire logic [15:0] base,
  // Offsets from the instruction.
  input wire logic [7:0] disp8,
  input wire logic [15:0] disp16,
  input wire logic short_ofs,
  // Effective address.
  output logic [15:0] sum
);

  logic [15:0] disp8_ext;
  logic [15:0] disp_sel;

  // Sign extension keeps the short reach at -128 to +127 around the base.
  assign disp8_ext = {{8{disp8[7]}}, disp8};
  assign disp_sel = short_ofs ? disp8_ext : disp16;
  assign sum = base + disp_sel;

endmodule : oas_index_add

// ---- verilog/oas_operand_addr.sv ----
// Purpose: Resolves operand effective addresses and keeps the 16-bit stack pointer.
// Assumes: Pointer bytes are fetched over a read port that answers one cycle after the strobe.
// Notes: Answers come as a one-cycle pulse; fetching modes hold off new requests meanwhile.
// Notes on behaviour
// - Stack pointer split into high and low bytes.
// - Stack pointer bytes have no reset value.
// - Low-byte carry or borrow reaches high byte.
// - High byte is plain data unless carried.
// - Low byte reachable by direct register form only; deref and index modes still fetch it through a window as a pointer byte.
// - Push decrements first; pop reads then increments.
// - Register mode uses the named register directly.
// - Window pointer selects an 8-byte working slice.
// - Field top bit picks pointer; concatenate bits.
// - Deref byte gives register; pair gives memory.
// - Deref cannot reach control range up to FFh.
// - Register index adds base to working offset.
// - Register index cannot reach control range.
// - Short memory offset is sign-extended byte.
// - Memory index adds offset to pair base.
// - Register index for load; memory for loads.
// - Absolute mode gives 16 bits; branches load PC.
// - Memory loads accept absolute 16-bit address.
// - Vector mode only for call, low page.
// - Vector location upper byte forced to zero.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module oas_operand_addr (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Decoded operand request and its answer.
  input oas_pkg::oas_req_s req,
  output logic req_ready,
  output oas_pkg::oas_resp_s resp,
  // Pointer byte fetch from register file or program memory.
  output logic fetch_en,
  output logic fetch_from_pm,
  output logic [15:0] fetch_addr,
  input wire logic [7:0] fetch_data
);
  import oas_pkg::*;

  typedef enum logic [1:0] {
    OAS_S_IDLE = 2'b00,
    OAS_S_FIRST = 2'b01,
    OAS_S_SECOND = 2'b10,
    OAS_S_FINISH = 2'b11
  } oas_state_e;

  logic rst_meta_r;
  logic rst_sync_n_r;
  logic [7:0] window_pointer_zero_r;
  logic [7:0] window_pointer_one_r;
  logic [7:0] stack_ptr_high_r;
  logic [7:0] stack_ptr_low_r;
  logic [7:0] reg_rdata_r;
  logic [7:0] reg_rdata_nxt;
  oas_state_e state_r;
  oas_state_e state_nxt;
  oas_req_s ctx_r;
  oas_req_s ctx_nxt;
  logic [7:0] hi_r;
  logic [7:0] hi_nxt;
  logic [7:0] lo_r;
  logic [7:0] lo_nxt;
  logic two_r;
  logic two_nxt;
  logic ready_r;
  logic ready_nxt;
  oas_resp_s resp_r;
  oas_resp_s resp_nxt;
  logic fetch_en_r;
  logic fetch_en_nxt;
  logic fetch_pm_r;
  logic fetch_pm_nxt;
  logic [15:0] fetch_addr_r;
  logic [15:0] fetch_addr_nxt;

  // Release the asynchronous reset through two flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // Register port decode.
  wire logic wr_wp0 = reg_wr && (reg_addr == OAS_OFS_WP0);
  wire logic wr_wp1 = reg_wr && (reg_addr == OAS_OFS_WP1);
  wire logic wr_sph = reg_wr && (reg_addr == OAS_OFS_SPH);
  wire logic wr_spl = reg_wr && (reg_addr == OAS_OFS_SPL);
  wire logic [7:0] rd_sel = (reg_addr == OAS_OFS_WP0) ? window_pointer_zero_r :
                            (reg_addr == OAS_OFS_WP1) ? window_pointer_one_r :
                            (reg_addr == OAS_OFS_SPH) ? stack_ptr_high_r :
                            (reg_addr == OAS_OFS_SPL) ? stack_ptr_low_r : OAS_BYTE_ZERO;

  // Read data stands only in the cycle after the strobe; unmapped reads give zero.
  assign reg_rdata_nxt = reg_rd ? rd_sel : OAS_BYTE_ZERO;

  // Window pointers come up on the common working area.
  always_ff @(posedge clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      window_pointer_zero_r <= OAS_WP0_RST;
      window_pointer_one_r <= OAS_WP1_RST;
      reg_rdata_r <= OAS_BYTE_ZERO;
    end else begin
      if (wr_wp0) begin
        window_pointer_zero_r <= reg_wdata;
      end
      if (wr_wp1) begin
        window_pointer_one_r <= reg_wdata;
      end
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  // Request acceptance and stack arithmetic.
  wire logic acc = req.valid && ready_r;
  wire logic stk_push = acc && (req.stk == OAS_K_PUSH);
  wire logic stk_pop = acc && (req.stk == OAS_K_POP);
  wire logic stk_take = stk_push || stk_pop;
  wire logic [15:0] stack_pointer = {stack_ptr_high_r, stack_ptr_low_r};
  wire logic [15:0] stack_dec = stack_pointer - OAS_ONE;
  wire logic [15:0] stack_inc = stack_pointer + OAS_ONE;
  wire logic [15:0] stack_next = stk_push ? stack_dec : stack_inc;
  // Push addresses the decremented slot; pop addresses the current top.
  wire logic [15:0] stack_addr = stk_push ? stack_dec : stack_pointer;

  // Stack pointer bytes carry no reset: their value is unknown until written.
  // A stack action in the same cycle as a software write takes precedence.
  always_ff @(posedge clk) begin
    if (stk_take) begin
      {stack_ptr_high_r, stack_ptr_low_r} <= stack_next;
    end else begin
      if (wr_sph) begin
        stack_ptr_high_r <= reg_wdata;
      end
      if (wr_spl) begin
        stack_ptr_low_r <= reg_wdata;
      end
    end
  end

  // Working register addresses for the short field and for an 8-bit field with the prefix.
  logic [7:0] work_a;
  logic [7:0] work_b;

  oas_window_sel u_work_short (
    .nibble(req.wreg),
    .window_pointer_zero(window_pointer_zero_r),
    .window_pointer_one(window_pointer_one_r),
    .addr(work_a)
  );

  oas_window_sel u_work_long (
    .nibble(req.field8[3:0]),
    .window_pointer_zero(window_pointer_zero_r),
    .window_pointer_one(window_pointer_one_r),
    .addr(work_b)
  );

  // Field decode shared by several modes.
  wire logic fld_is_work = (req.field8[7:4] == OAS_WORK_PREFIX);
  wire logic [7:0] reg_mode_addr = fld_is_work ? work_b : req.field8;
  wire logic [7:0] reg_pair_addr = {reg_mode_addr[7:1], 1'b0};
  wire logic [7:0] deref_ptr = req.wide ? reg_pair_addr : reg_mode_addr;
  wire logic [7:0] work_pair = {work_a[7:1], 1'b0};
  wire logic req_memcls = (req.cls == OAS_C_PMLOAD) || (req.cls == OAS_C_XLOAD);
  wire logic req_branch = (req.cls == OAS_C_JUMP) || (req.cls == OAS_C_CALL);
  wire oas_target_e req_mem_tgt = (req.cls == OAS_C_PMLOAD) ? OAS_T_PM : OAS_T_XM;
  // The low stack byte is refused to the working-register mode and to prefixed fields in register mode, even when a window covers it.
  wire logic work_hits_spl = (work_a == OAS_OFS_SPL);
  wire logic long_hits_spl = fld_is_work && (work_b == OAS_OFS_SPL);

  logic imm_fault;
  oas_target_e imm_target;
  logic [15:0] imm_addr;
  logic need_fetch;
  logic two_bytes;
  logic first_pm;
  logic [15:0] first_addr;

  // Resolution at acceptance: direct answers, or the first pointer byte to fetch.
  always_comb begin
    imm_fault = 1'b0;
    imm_target = OAS_T_RF;
    imm_addr = OAS_WORD_ZERO;
    need_fetch = 1'b0;
    two_bytes = 1'b0;
    first_pm = 1'b0;
    first_addr = OAS_WORD_ZERO;
    unique case (req.mode)
      OAS_M_REG: begin
        imm_addr = {OAS_BYTE_ZERO, (req.wide ? reg_pair_addr : reg_mode_addr)};
        imm_fault = long_hits_spl;
      end
      OAS_M_WORK: begin
        imm_addr = {OAS_BYTE_ZERO, work_a};
        imm_fault = work_hits_spl;
      end
      OAS_M_DEREF: begin
        need_fetch = 1'b1;
        two_bytes = req.wide;
        first_addr = {OAS_BYTE_ZERO, deref_ptr};
      end
      OAS_M_INDEX: begin
        if (req.cls == OAS_C_LOAD) begin
          need_fetch = 1'b1;
          first_addr = {OAS_BYTE_ZERO, work_a};
        end else if (req_memcls) begin
          need_fetch = 1'b1;
          two_bytes = 1'b1;
          first_addr = {OAS_BYTE_ZERO, work_pair};
        end else begin
          imm_fault = 1'b1;
        end
      end
      OAS_M_ABS: begin
        imm_addr = req.field16;
        if (req_branch) begin
          imm_target = OAS_T_PC;
        end else if (req_memcls) begin
          imm_target = req_mem_tgt;
        end else begin
          imm_fault = 1'b1;
        end
      end
      OAS_M_VEC: begin
        if (req.cls == OAS_C_CALL) begin
          need_fetch = 1'b1;
          two_bytes = 1'b1;
          first_pm = 1'b1;
          first_addr = {OAS_VEC_PAGE, req.field8};
        end else begin
          imm_fault = 1'b1;
        end
      end
      default: begin
        imm_fault = 1'b1;
      end
    endcase
  end

  // Completion of fetching modes from the captured pointer bytes.
  wire logic [15:0] fin_pair = {hi_r, lo_r};
  wire logic [7:0] fin_rf_index = ctx_r.field8 + hi_r;
  wire logic ctx_memcls = (ctx_r.cls == OAS_C_PMLOAD) || (ctx_r.cls == OAS_C_XLOAD);
  wire oas_target_e ctx_mem_tgt = (ctx_r.cls == OAS_C_PMLOAD) ? OAS_T_PM : OAS_T_XM;
  logic [15:0] index_sum;
  logic fin_fault;
  oas_target_e fin_target;
  logic [15:0] fin_addr;

  oas_index_add u_index_add (
    .base(fin_pair),
    .disp8(ctx_r.field8),
    .disp16(ctx_r.field16),
    .short_ofs(ctx_r.short_ofs),
    .sum(index_sum)
  );

  always_comb begin
    fin_fault = 1'b0;
    fin_target = OAS_T_RF;
    fin_addr = OAS_WORD_ZERO;
    unique case (ctx_r.mode)
      OAS_M_DEREF: begin
        if (ctx_r.wide) begin
          fin_addr = fin_pair;
          fin_target = ctx_mem_tgt;
          fin_fault = !ctx_memcls;
        end else begin
          fin_addr = {OAS_BYTE_ZERO, hi_r};
          fin_fault = (hi_r >= OAS_SET1_BASE);
        end
      end
      OAS_M_INDEX: begin
        if (ctx_r.cls == OAS_C_LOAD) begin
          fin_addr = {OAS_BYTE_ZERO, fin_rf_index};
          fin_fault = (fin_rf_index >= OAS_SET1_BASE);
        end else begin
          fin_addr = index_sum;
          fin_target = ctx_mem_tgt;
        end
      end
      OAS_M_VEC: begin
        fin_addr = fin_pair;
        fin_target = OAS_T_PC;
      end
      default: begin
        fin_fault = 1'b1;
      end
    endcase
  end

  // Sequencer: the answer waits until every pointer byte has arrived.
  always_comb begin
    state_nxt = state_r;
    ctx_nxt = ctx_r;
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    two_nxt = two_r;
    ready_nxt = ready_r;
    resp_nxt = '0;
    fetch_en_nxt = 1'b0;
    fetch_pm_nxt = fetch_pm_r;
    fetch_addr_nxt = fetch_addr_r;
    unique case (state_r)
      OAS_S_IDLE: begin
        if (acc) begin
          if (stk_take) begin
            resp_nxt.valid = 1'b1;
            resp_nxt.target = OAS_T_RF;
            resp_nxt.addr = stack_addr;
          end else if (need_fetch) begin
            ready_nxt = 1'b0;
            fetch_en_nxt = 1'b1;
            fetch_pm_nxt = first_pm;
            fetch_addr_nxt = first_addr;
            ctx_nxt = req;
            two_nxt = two_bytes;
            state_nxt = OAS_S_FIRST;
          end else begin
            resp_nxt.valid = 1'b1;
            resp_nxt.fault = imm_fault;
            resp_nxt.target = imm_target;
            resp_nxt.addr = imm_addr;
          end
        end
      end
      OAS_S_FIRST: begin
        if (!fetch_en_r) begin
          hi_nxt = fetch_data;
          if (two_r) begin
            fetch_en_nxt = 1'b1;
            fetch_addr_nxt = fetch_addr_r + OAS_ONE;
            state_nxt = OAS_S_SECOND;
          end else begin
            state_nxt = OAS_S_FINISH;
          end
        end
      end
      OAS_S_SECOND: begin
        if (!fetch_en_r) begin
          lo_nxt = fetch_data;
          state_nxt = OAS_S_FINISH;
        end
      end
      OAS_S_FINISH: begin
        resp_nxt.valid = 1'b1;
        resp_nxt.fault = fin_fault;
        resp_nxt.target = fin_target;
        resp_nxt.addr = fin_addr;
        ready_nxt = 1'b1;
        state_nxt = OAS_S_IDLE;
      end
    endcase
  end

  // Sequencer state.
  always_ff @(posedge clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      state_r <= OAS_S_IDLE;
      ctx_r <= '0;
      hi_r <= OAS_BYTE_ZERO;
      lo_r <= OAS_BYTE_ZERO;
      two_r <= 1'b0;
      ready_r <= 1'b0;
      resp_r <= '0;
    end else begin
      state_r <= state_nxt;
      ctx_r <= ctx_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      two_r <= two_nxt;
      ready_r <= (state_r == OAS_S_IDLE) ? ready_nxt | ~ready_r & ~acc : ready_nxt;
      resp_r <= resp_nxt;
    end
  end

  // Fetch port registers.
  always_ff @(posedge clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      fetch_en_r <= 1'b0;
      fetch_pm_r <= 1'b0;
      fetch_addr_r <= OAS_WORD_ZERO;
    end else begin
      fetch_en_r <= fetch_en_nxt;
      fetch_pm_r <= fetch_pm_nxt;
      fetch_addr_r <= fetch_addr_nxt;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign req_ready = ready_r;
  assign resp = resp_r;
  assign fetch_en = fetch_en_r;
  assign fetch_from_pm = fetch_pm_r;
  assign fetch_addr = fetch_addr_r;

  // Checks on the design's own outputs.
  default clocking oas_cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_n_r);

  wire logic acc_plain = acc && (req.stk == OAS_K_NONE);

  // The high stack byte has no reset, so the hold check waits until software has loaded it.
  logic sph_loaded_r;
  always_ff @(posedge clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      sph_loaded_r <= 1'b0;
    end else if (wr_sph && !stk_take) begin
      sph_loaded_r <= 1'b1;
    end
  end
  wire logic [7:0] chk_window = req.wreg[3] ? window_pointer_one_r : window_pointer_zero_r;

  AST_PUSH_DEC: assert property (stk_push |=>
    resp_r.valid && (resp_r.addr == $past(stack_pointer) - OAS_ONE) && (stack_pointer == resp_r.addr))
    else $error("Push did not predecrement the stack pointer.");

  AST_POP_INC: assert property (stk_pop |=>
    resp_r.valid && (resp_r.addr == $past(stack_pointer)) && (stack_pointer == $past(stack_pointer) + OAS_ONE))
    else $error("Pop did not address the top and then increment.");

  AST_CARRY_HIGH: assert property (stk_pop && (stack_ptr_low_r == 8'hFF) |=>
    (stack_ptr_low_r == 8'h00) && (stack_ptr_high_r == $past(stack_ptr_high_r) + 8'h01))
    else $error("Low byte carry did not reach the high byte.");

  AST_HIGH_HOLD: assert property (sph_loaded_r && !stk_take && !wr_sph |=> $stable(stack_ptr_high_r))
    else $error("High stack byte changed without a write or carry.");

  AST_WORK_ADDR: assert property (acc_plain && (req.mode == OAS_M_WORK) |=>
    resp_r.valid && (resp_r.addr[7:0] == {$past(chk_window[7:3]), $past(req.wreg[2:0])}))
    else $error("Working register address formed wrongly.");

  AST_DEREF_SET1: assert property ((state_r == OAS_S_FINISH) && (ctx_r.mode == OAS_M_DEREF)
    && !ctx_r.wide && (hi_r >= OAS_SET1_BASE) |=> resp_r.valid && resp_r.fault)
    else $error("Deref reached the control register range.");

  AST_INDEX_SET1: assert property ((state_r == OAS_S_FINISH) && (ctx_r.mode == OAS_M_INDEX)
    && (ctx_r.cls == OAS_C_LOAD) |=> resp_r.fault == ($past(fin_rf_index) >= OAS_SET1_BASE))
    else $error("Register index range check wrong.");

  AST_ABS_PC: assert property (acc_plain && (req.mode == OAS_M_ABS) && req_branch |=>
    resp_r.valid && !resp_r.fault && (resp_r.target == OAS_T_PC) && (resp_r.addr == $past(req.field16)))
    else $error("Branch absolute address not passed to the program counter.");

  AST_VEC_CALL_ONLY: assert property (acc_plain && (req.mode == OAS_M_VEC) && (req.cls != OAS_C_CALL) |=>
    resp_r.valid && resp_r.fault)
    else $error("Vector mode accepted for a non-call.");

  AST_VEC_PAGE: assert property (acc_plain && (req.mode == OAS_M_VEC) && (req.cls == OAS_C_CALL) |=>
    fetch_en_r && fetch_pm_r && (fetch_addr_r == {OAS_VEC_PAGE, $past(req.field8)}) ##2 fetch_en_r)
    else $error("Vector location not fetched from the low page.");

  AST_NO_EARLY_RESP: assert property ((state_r == OAS_S_FIRST) |-> !resp_r.valid && !ready_r)
    else $error("Answer given before pointer bytes arrived.");

endmodule : oas_operand_addr

// ---- verification/oas_fetch_model.sv ----
// Purpose: Register file and program memory as seen by the pointer fetch port.
// Assumes: A byte is wanted exactly one cycle after the fetch strobe.
// Notes: Contents follow a fixed pattern so the bench can predict every byte.
`timescale 1ns/1ps
module oas_fetch_model (
  // Clock.
  input wire logic clk,
  // Fetch request.
  input wire logic fetch_en,
  input wire logic fetch_from_pm,
  input wire logic [15:0] fetch_addr,
  // Returned byte.
  output logic [7:0] fetch_data
);
  initial fetch_data = 8'h00;
  // The byte stands one cycle only; afterwards it inverts so a late sample cannot match.
  always @(posedge clk) begin
    if (fetch_en) begin
      fetch_data <= fetch_from_pm ? fetch_addr[7:0] + 8'h11 : fetch_addr[7:0] ^ 8'h3C;
    end else begin
      fetch_data <= ~fetch_data;
    end
  end
endmodule : oas_fetch_model

// ---- verification/test_oas_operand_addr.sv ----
// Purpose: Self-checking bench for operand address resolution and the stack pointer.
// Assumes: Register file bytes are addr^3Ch, program memory bytes are addr+11h.
// Notes: Memory requests are wide and take the short offset when field16 is zero.
`timescale 1ns/1ps
module test_oas_operand_addr;
  import oas_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  oas_req_s req = '0;
  logic req_ready;
  oas_resp_s resp;
  logic fetch_en;
  logic fetch_from_pm;
  logic [15:0] fetch_addr;
  logic [7:0] fetch_data;
  int miscompares = 0;
  int checks_done = 0;

  // Clock of 20 ns period.
  always #10 clk = ~clk;

  oas_operand_addr uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .req_ready(req_ready), .resp(resp), .fetch_en(fetch_en),
    .fetch_from_pm(fetch_from_pm), .fetch_addr(fetch_addr), .fetch_data(fetch_data));
  oas_fetch_model mem (.clk(clk), .fetch_en(fetch_en), .fetch_from_pm(fetch_from_pm), .fetch_addr(fetch_addr),
    .fetch_data(fetch_data));

  // Prints the counts and the verdict, then stops.
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // Register write; ends just after the edge that drops the strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Register read; the data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 1'b0;
    #1;
    checks_done++;
    if (reg_rdata !== exp) begin
      miscompares++;
      $display("ERROR %0t read %h gave %h, wanted %h", $time, a, reg_rdata, exp);
    end
  endtask : rd

  // One operand request; waits a bounded time for the answer, then compares it.
  task automatic op(input oas_mode_e m, input oas_cls_e c, input oas_stk_e k, input logic [3:0] w,
                    input logic [7:0] f8, input logic [15:0] f16, input logic f, input oas_target_e t,
                    input logic [15:0] a);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk) req <= '{valid: 1'b1, mode: m, cls: c, stk: k, wide: (c == OAS_C_PMLOAD || c == OAS_C_XLOAD),
                            short_ofs: (f16 == 16'h0000), wreg: w, field8: f8, field16: f16};
    // A direct answer is a one-cycle pulse that already stands just after the accepting edge.
    @(posedge clk) req <= '0;
    #1;
    for (n = 0; n < 10 && resp.valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    checks_done++;
    if (resp.valid !== 1'b1 || resp.fault !== f || (!f && (resp.target !== t || resp.addr !== a))) begin
      miscompares++;
      $display("ERROR %0t answer %h, wanted fault %b target %0d addr %h", $time, resp, f, t, a);
    end
  endtask : op

  // Watchdog: the tests need well under 1000 cycles.
  initial begin
    #(20 * 4000);
    miscompares++;
    conclude();
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rd(OAS_OFS_WP0, 8'hC0);
    rd(8'h40, 8'h00);
    wr(OAS_OFS_SPH, 8'h12);
    wr(OAS_OFS_SPL, 8'h00);
    rd(OAS_OFS_SPH, 8'h12);
    rd(OAS_OFS_SPL, 8'h00);
    op(OAS_M_REG, OAS_C_OTHER, OAS_K_PUSH, 4'h0, 8'h00, 16'h0, 1'b0, OAS_T_RF, 16'h11FF);
    rd(OAS_OFS_SPH, 8'h11);
    op(OAS_M_REG, OAS_C_OTHER, OAS_K_POP, 4'h0, 8'h00, 16'h0, 1'b0, OAS_T_RF, 16'h11FF);
    rd(OAS_OFS_SPH, 8'h12);
    wr(OAS_OFS_SPL, 8'hFF);
    wr(OAS_OFS_SPH, 8'h5A);
    op(OAS_M_REG, OAS_C_OTHER, OAS_K_PUSH, 4'h0, 8'h00, 16'h0, 1'b0, OAS_T_RF, 16'h5AFE);
    rd(OAS_OFS_SPH, 8'h5A);
    wr(OAS_OFS_WP0, 8'h70);
    wr(OAS_OFS_WP1, 8'hA8);
    op(OAS_M_WORK, OAS_C_OTHER, OAS_K_NONE, 4'h6, 8'hC6, 16'h0, 1'b0, OAS_T_RF, 16'h0076);
    op(OAS_M_WORK, OAS_C_OTHER, OAS_K_NONE, 4'hB, 8'hCB, 16'h0, 1'b0, OAS_T_RF, 16'h00AB);
    op(OAS_M_REG, OAS_C_OTHER, OAS_K_NONE, 4'h0, 8'h40, 16'h0, 1'b0, OAS_T_RF, 16'h0040);
    op(OAS_M_REG, OAS_C_OTHER, OAS_K_NONE, 4'h0, 8'hC1, 16'h0, 1'b0, OAS_T_RF, 16'h0071);
    op(OAS_M_ABS, OAS_C_JUMP, OAS_K_NONE, 4'h0, 8'h00, 16'h1234, 1'b0, OAS_T_PC, 16'h1234);
    op(OAS_M_ABS, OAS_C_PMLOAD, OAS_K_NONE, 4'h0, 8'h00, 16'h1234, 1'b0, OAS_T_PM, 16'h1234);
    op(OAS_M_ABS, OAS_C_XLOAD, OAS_K_NONE, 4'h0, 8'h00, 16'h1234, 1'b0, OAS_T_XM, 16'h1234);
    op(OAS_M_ABS, OAS_C_OTHER, OAS_K_NONE, 4'h0, 8'h00, 16'h1234, 1'b1, OAS_T_RF, 16'h0);
    op(OAS_M_VEC, OAS_C_CALL, OAS_K_NONE, 4'h0, 8'h40, 16'h0, 1'b0, OAS_T_PC, 16'h5152);
    op(OAS_M_VEC, OAS_C_JUMP, OAS_K_NONE, 4'h0, 8'h40, 16'h0, 1'b1, OAS_T_RF, 16'h0);
    op(OAS_M_DEREF, OAS_C_OTHER, OAS_K_NONE, 4'h0, 8'h20, 16'h0, 1'b0, OAS_T_RF, 16'h001C);
    op(OAS_M_DEREF, OAS_C_OTHER, OAS_K_NONE, 4'h0, 8'hFC, 16'h0, 1'b1, OAS_T_RF, 16'h0);
    op(OAS_M_DEREF, OAS_C_PMLOAD, OAS_K_NONE, 4'h0, 8'h31, 16'h0, 1'b0, OAS_T_PM, 16'h0C0D);
    op(OAS_M_INDEX, OAS_C_LOAD, OAS_K_NONE, 4'h2, 8'h10, 16'h0, 1'b0, OAS_T_RF, 16'h005E);
    op(OAS_M_INDEX, OAS_C_LOAD, OAS_K_NONE, 4'h2, 8'h80, 16'h0, 1'b1, OAS_T_RF, 16'h0);
    op(OAS_M_INDEX, OAS_C_OTHER, OAS_K_NONE, 4'h2, 8'h10, 16'h0, 1'b1, OAS_T_RF, 16'h0);
    op(OAS_M_INDEX, OAS_C_XLOAD, OAS_K_NONE, 4'h4, 8'h80, 16'h0, 1'b0, OAS_T_XM, 16'h47C9);
    op(OAS_M_INDEX, OAS_C_XLOAD, OAS_K_NONE, 4'h4, 8'h7F, 16'h0, 1'b0, OAS_T_XM, 16'h48C8);
    op(OAS_M_INDEX, OAS_C_PMLOAD, OAS_K_NONE, 4'h4, 8'h00, 16'h1000, 1'b0, OAS_T_PM, 16'h5849);
    wr(OAS_OFS_WP1, 8'hD8);
    op(OAS_M_REG, OAS_C_OTHER, OAS_K_NONE, 4'h0, 8'hC9, 16'h0, 1'b1, OAS_T_RF, 16'h0);
    op(OAS_M_WORK, OAS_C_OTHER, OAS_K_NONE, 4'h9, 8'h00, 16'h0, 1'b1, OAS_T_RF, 16'h0);
    conclude();
  end
endmodule : test_oas_operand_addr
